// >>> bwrtc_assertions.sv
/*
  Checker of the pin bus, supply blocking and slave outputs of bwrtc_top.
  Sees only top ports; bound to every bwrtc_top at the foot of this file.
*/
`timescale 1ns/100ps
`default_nettype none
module bwrtc_chk #(
  parameter [24:0] SEC_CYCLES = 25'd10,
  parameter [12:0] REC_CYCLES = 13'd8
) (
  input wire logic        CLOCK,
  input wire logic        RSTN,
  input wire logic [12:0] ADDRESS_LINE,
  input wire logic [7:0]  DATA_LINE_OUT,
  input wire logic        DATA_LINE_OE_N,
  input wire logic        CHIP_SELECT_N,
  input wire logic        SECOND_CHIP_SELECT,
  input wire logic        OUTPUT_ENABLE_N,
  input wire logic        WRITE_STROBE_N,
  input wire logic        POWER_BELOW_THRESHOLD,
  input wire logic        BATTERY_LOW,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  input wire logic        IRQ
);
  logic [15:0] quiet_cnt;
  wire         rd_cond = !CHIP_SELECT_N && SECOND_CHIP_SELECT && !OUTPUT_ENABLE_N && WRITE_STROBE_N;
  // open only well past any recovery interval
  wire         open = quiet_cnt > ({3'h0, REC_CYCLES} + 16'h3);
  always @(posedge CLOCK) begin
    if (!RSTN) quiet_cnt <= 16'hffff;
    else if (POWER_BELOW_THRESHOLD) quiet_cnt <= 16'h0;
    else if (quiet_cnt != 16'hffff) quiet_cnt <= quiet_cnt + 16'h1;
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  sequence rd_req_s; open && rd_cond; endsequence
  sequence flag_rd_s; BATTERY_LOW [*3] ##0 rd_req_s ##0 (ADDRESS_LINE == 13'h1ffc); endsequence
  read_drive_a: assert property (rd_req_s |=> !DATA_LINE_OE_N)
    else $error("read cycle not answered");
  idle_float_a: assert property (!rd_cond |=> DATA_LINE_OE_N)
    else $error("data driven without read");
  fail_float_a: assert property (POWER_BELOW_THRESHOLD [*2] |=> DATA_LINE_OE_N)
    else $error("data driven below threshold");
  recover_block_a: assert property ($past(RSTN) && $fell(POWER_BELOW_THRESHOLD)
    |=> DATA_LINE_OE_N [*6]) else $error("access during recovery");
  flag_shown_a: assert property (flag_rd_s |=> DATA_LINE_OUT[7])
    else $error("low battery flag not shown");
  ram_stable_a: assert property (rd_req_s ##1 rd_req_s ##0
    ($stable(ADDRESS_LINE) && ADDRESS_LINE < 13'h1ff8) |=> $stable(DATA_LINE_OUT))
    else $error("ram data moved");
  bus_okay_a: assert property (HREADYOUT && !HRESP) else $error("slave not ready or error");
  irq_reset_a: assert property (!$past(RSTN) |-> !IRQ && DATA_LINE_OE_N)
    else $error("outputs active after reset");
endmodule // bwrtc_chk
bind bwrtc_top bwrtc_chk #(.SEC_CYCLES(SEC_CYCLES), .REC_CYCLES(REC_CYCLES)) chk (.*);
`default_nettype wire

// >>> bwrtc_host.sv
/*
  Host model driving the bytewide pin bus: byte writes, byte reads and
  the freeze release wait. Assumes the caller enters tasks just after an edge.
*/
`timescale 1ns/100ps
`default_nettype none
module bwrtc_host (
  input wire logic        clock,
  output logic     [12:0] addr_line,
  output logic     [7:0]  data_in,
  output logic            cs_n,
  output logic            cs2,
  output logic            oe_n,
  output logic            we_n,
  input wire logic [7:0]  data_out,
  input wire logic        data_oe_n
);
  initial begin
    addr_line = 13'h0;
    data_in = 8'h0;
    {cs_n, cs2, oe_n, we_n} = 4'hb;
  end
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    addr_line <= a;
    data_in <= d;
    {cs_n, cs2, we_n} <= 3'b010;
    @(posedge clock);
    {cs_n, cs2, we_n} <= 3'b101;
    data_in <= ~d;
    @(posedge clock);
  endtask
  // a blocked read gives up after four edges
  task automatic rd(input logic [12:0] a, input logic sel2, output logic [7:0] d, output logic ok);
    int n;
    addr_line <= a;
    {cs_n, cs2, oe_n} <= {1'b0, sel2, 1'b0};
    ok = 1'b0;
    d = 8'h0;
    for (n = 0; n < 4 && !ok; n++) begin
      @(posedge clock);
      if (data_oe_n === 1'b0) begin
        ok = 1'b1;
        d = data_out;
      end
    end
    {cs_n, cs2, oe_n} <= 3'b101;
    @(posedge clock);
  endtask
  task automatic thaw();
    wr(13'h1ff8, 8'h00);
    repeat (12500) @(posedge clock);
  endtask
endmodule // bwrtc_host
`default_nettype wire

// >>> bwrtc_map.vh
/*
  Constants of the bytewide timekeeping memory: clock register addresses,
  control bit positions, reset values, timing figures and the offsets of the
  small AHB-Lite interrupt and status window. Assumes a 25 MHz system clock.
*/
`ifndef BWRTC_MAP_VH
`define BWRTC_MAP_VH

`define BW_CLK_HZ      25'd25000000
`define BW_CLK_MHZ     25
// recovery interval after the supply returns, in microseconds
`define BW_RECOVERY_INTERVAL_US     200
// the same interval counted in 25 MHz cycles
`define BW_RECOVERY_INTERVAL_CYC    13'd5000

// clock registers in the eight top bytes
`define BW_CLK_BASE    10'h3ff
`define BW_ADDR_CTRL   3'h0
`define BW_ADDR_SEC    3'h1
`define BW_ADDR_MIN    3'h2
`define BW_ADDR_HOUR   3'h3
`define BW_ADDR_DAY    3'h4
`define BW_ADDR_DATE   3'h5
`define BW_ADDR_MON    3'h6
`define BW_ADDR_YEAR   3'h7

`define BW_CTRL_LOAD   7
`define BW_CTRL_FREEZE 6
`define BW_SEC_OSC     7
`define BW_DAY_BATT    7

// reset time point: 00:00:00, day 1, 2000-01-01
`define BW_RST_CEN     6'h20
`define BW_RST_ONE     8'h01
`define BW_RST_ZERO    8'h00

// AHB-Lite window
`define BW_AHB_IRQ_ST  4'h0
`define BW_AHB_IRQ_MSK 4'h4
`define BW_AHB_STATUS  4'h8
`define BW_IRQ_TICK    0
`define BW_IRQ_PFAIL   1
`define BW_IRQ_READY   2
`define BW_IRQ_BATT    3

`endif

// >>> bwrtc_top.v
/*
  Bytewide nonvolatile memory with a BCD clock and calendar in its eight top
  bytes, host side on a parallel asynchronous bus sampled by CLOCK, plus an
  AHB-Lite slave for interrupt status, mask and supply state.
  Assumes the pin inputs are synchronous to CLOCK and that POWER_BELOW_THRESHOLD
  and BATTERY_LOW come from an external supply monitor.
*/
// Function
// RULE1 - one 8192 by 8 byte array reached through the same address and data lines.
// RULE2 - clock, calendar and control bytes sit at the eight top addresses and use memory cycles.
// RULE3 - century, year, month, date, day, hours, minutes and seconds are BCD, hours 0 to 23.
// RULE4 - month lengths adjust and leap days are inserted for every year through 2099.
// RULE5 - counting registers are apart from the visible copies and keep counting during access.
// RULE6 - below the power fail threshold the chip select is forced off and data lines float.
// RULE7 - after the supply returns, access stays blocked for the recovery interval.
// RULE8 - a readable flag shows a low backup energy source.
// RULE9 - the load bit halts visible updates, and writing 00h loads the new time and resumes.
// RULE10 - the freeze bit halts visible updates while internal counting goes on.
// RULE11 - the host leaves the freeze bit clear for 500 us so the visible copy refreshes.
// RULE12 - century bits 5:0 change only on a control write that clears the load bit; the code also steps them when the year rolls over from 99.
// RULE13 - each counter carries into the next higher field when it rolls over.
// RULE14 - a cycle is valid with chip select low and second chip select high, write on strobe low.
`timescale 1ns/100ps
`include "bwrtc_map.vh"
`default_nettype none

module bwrtc_top #(
  parameter [24:0] SEC_CYCLES = `BW_CLK_HZ,
  parameter [12:0] REC_CYCLES = `BW_RECOVERY_INTERVAL_CYC
) (
  input  wire        CLOCK,
  input  wire        RSTN,
  input  wire [12:0] ADDRESS_LINE,
  input  wire [7:0]  DATA_LINE_IN,
  output reg  [7:0]  DATA_LINE_OUT,
  output reg         DATA_LINE_OE_N,
  input  wire        CHIP_SELECT_N,
  input  wire        SECOND_CHIP_SELECT,
  input  wire        OUTPUT_ENABLE_N,
  input  wire        WRITE_STROBE_N,
  input  wire        POWER_BELOW_THRESHOLD,
  input  wire        BATTERY_LOW,
  input  wire        HSEL,
  input  wire [31:0] HADDR,
  input  wire        HWRITE,
  input  wire [1:0]  HTRANS,
  input  wire [2:0]  HSIZE,
  input  wire [31:0] HWDATA,
  input  wire        HREADY,
  output reg  [31:0] HRDATA,
  output reg         HREADYOUT,
  output reg         HRESP,
  output reg         IRQ
);

  function [7:0] bcd_inc;
    input [7:0] v;
    begin
      if (v[3:0] == 4'h9)
        bcd_inc = {v[7:4] + 4'h1, 4'h0};
      else
        bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // last date of the month; year 00 counts as leap (2000)
  function [7:0] month_end;
    input [7:0] mon;
    input [7:0] yr;
    reg         leap;
    begin
      leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6) :
                     (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
      case (mon)
        8'h02:   month_end = leap ? 8'h29 : 8'h28;
        8'h04:   month_end = 8'h30;
        8'h06:   month_end = 8'h30;
        8'h09:   month_end = 8'h30;
        8'h11:   month_end = 8'h30;
        default: month_end = 8'h31;
      endcase
    end
  endfunction

  reg  [7:0]  mem [0:8191];
  reg  [24:0] div_reg;
  reg         tick_reg;
  reg  [12:0] rec_reg;
  reg         pf_reg;
  reg         batt_reg;
  reg  [7:0]  cnt_sec_reg;
  reg  [7:0]  cnt_min_reg;
  reg  [7:0]  cnt_hour_reg;
  reg  [7:0]  cnt_day_reg;
  reg  [7:0]  cnt_date_reg;
  reg  [7:0]  cnt_mon_reg;
  reg  [7:0]  cnt_year_reg;
  reg  [5:0]  cnt_cen_reg;
  reg  [7:0]  vis_sec_reg;
  reg  [7:0]  vis_min_reg;
  reg  [7:0]  vis_hour_reg;
  reg  [7:0]  vis_day_reg;
  reg  [7:0]  vis_date_reg;
  reg  [7:0]  vis_mon_reg;
  reg  [7:0]  vis_year_reg;
  reg  [5:0]  vis_cen_reg;
  reg         load_bit_reg;
  reg         freeze_bit_reg;
  reg         osc_stop_reg;
  reg  [7:0]  clk_rd;
  reg  [3:0]  irq_st_reg;
  reg  [3:0]  irq_msk_reg;
  reg  [3:0]  irq_clr;
  reg         ahb_wr_reg;
  reg  [3:0]  ahb_addr_reg;
  reg  [31:0] ahb_rd;

  wire        blocked    = pf_reg | (rec_reg != 13'h0000);
  wire        sel        = ~CHIP_SELECT_N & SECOND_CHIP_SELECT & ~blocked; // [RULE14] [RULE6]
  wire        wr         = sel & ~WRITE_STROBE_N;                         // [RULE14]
  wire        rd         = sel & ~OUTPUT_ENABLE_N & WRITE_STROBE_N;       // [RULE14]
  wire        clk_region = (ADDRESS_LINE[12:3] == `BW_CLK_BASE);          // [RULE2]
  wire [2:0]  idx        = ADDRESS_LINE[2:0];
  wire        ctrl_wr    = wr & clk_region & (idx == `BW_ADDR_CTRL);
  wire        load       = ctrl_wr & load_bit_reg & (DATA_LINE_IN[7:6] == 2'b00);
  wire        step       = tick_reg & ~osc_stop_reg;
  wire        halted     = load_bit_reg | freeze_bit_reg;
  wire        sec_w      = (cnt_sec_reg == 8'h59);
  wire        min_w      = (cnt_min_reg == 8'h59);
  wire        hour_w     = (cnt_hour_reg == 8'h23);
  wire        date_w     = (cnt_date_reg == month_end(cnt_mon_reg, cnt_year_reg));
  wire        mon_w      = (cnt_mon_reg == 8'h12);
  wire        year_w     = (cnt_year_reg == 8'h99);
  wire [7:0]  cen_inc    = bcd_inc({2'b00, cnt_cen_reg});
  wire [3:0]  irq_ev;
  wire        ahb_take   = HSEL & HTRANS[1] & HREADY;

  // one second enable pulse
  always @(posedge CLOCK) begin
    if (!RSTN) begin
      div_reg  <= 25'h0000000;
      tick_reg <= 1'b0;
    end else if (div_reg == SEC_CYCLES - 25'h0000001) begin
      div_reg  <= 25'h0000000;
      tick_reg <= 1'b1;
    end else begin
      div_reg  <= div_reg + 25'h0000001;
      tick_reg <= 1'b0;
    end
  end

  // supply gate: blocked while low and for the recovery interval after
  always @(posedge CLOCK) begin
    if (!RSTN) begin
      pf_reg   <= 1'b0;
      rec_reg  <= 13'h0000;
      batt_reg <= 1'b0;
    end else begin
      pf_reg   <= POWER_BELOW_THRESHOLD;                                 // [RULE6]
      batt_reg <= BATTERY_LOW;                                           // [RULE8]
      if (pf_reg)
        rec_reg <= REC_CYCLES;                                           // [RULE7]
      else if (rec_reg != 13'h0000)
        rec_reg <= rec_reg - 13'h0001;                                   // [RULE7]
    end
  end

  // internal counting chain
  always @(posedge CLOCK) begin
    if (!RSTN) begin
      cnt_sec_reg  <= `BW_RST_ZERO;
      cnt_min_reg  <= `BW_RST_ZERO;
      cnt_hour_reg <= `BW_RST_ZERO;
      cnt_day_reg  <= `BW_RST_ONE;
      cnt_date_reg <= `BW_RST_ONE;
      cnt_mon_reg  <= `BW_RST_ONE;
      cnt_year_reg <= `BW_RST_ZERO;
      cnt_cen_reg  <= `BW_RST_CEN;
    end else if (load) begin
      cnt_sec_reg  <= {1'b0, vis_sec_reg[6:0]};                          // [RULE9]
      cnt_min_reg  <= vis_min_reg;
      cnt_hour_reg <= vis_hour_reg;
      cnt_day_reg  <= vis_day_reg;
      cnt_date_reg <= vis_date_reg;
      cnt_mon_reg  <= vis_mon_reg;
      cnt_year_reg <= vis_year_reg;
      cnt_cen_reg  <= DATA_LINE_IN[5:0];                                 // [RULE12]
    end else if (step) begin
      cnt_sec_reg <= sec_w ? 8'h00 : bcd_inc(cnt_sec_reg);               // [RULE3] [RULE5]
      if (sec_w) begin
        cnt_min_reg <= min_w ? 8'h00 : bcd_inc(cnt_min_reg);             // [RULE13]
        if (min_w) begin
          cnt_hour_reg <= hour_w ? 8'h00 : bcd_inc(cnt_hour_reg);        // [RULE3] [RULE13]
          if (hour_w) begin
            cnt_day_reg  <= (cnt_day_reg == 8'h07) ? 8'h01 : bcd_inc(cnt_day_reg);
            cnt_date_reg <= date_w ? 8'h01 : bcd_inc(cnt_date_reg);      // [RULE4] [RULE13]
            if (date_w) begin
              cnt_mon_reg <= mon_w ? 8'h01 : bcd_inc(cnt_mon_reg);       // [RULE13]
              if (mon_w) begin
                cnt_year_reg <= year_w ? 8'h00 : bcd_inc(cnt_year_reg);  // [RULE13]
                if (year_w)
                  cnt_cen_reg <= (cnt_cen_reg == 6'h39) ? 6'h00 : cen_inc[5:0];
              end
            end
          end
        end
      end
    end
  end

  // visible copies: refreshed from the counters unless halted, host writes win
  always @(posedge CLOCK) begin
    if (!RSTN) begin
      vis_sec_reg    <= `BW_RST_ZERO;
      vis_min_reg    <= `BW_RST_ZERO;
      vis_hour_reg   <= `BW_RST_ZERO;
      vis_day_reg    <= `BW_RST_ONE;
      vis_date_reg   <= `BW_RST_ONE;
      vis_mon_reg    <= `BW_RST_ONE;
      vis_year_reg   <= `BW_RST_ZERO;
      vis_cen_reg    <= `BW_RST_CEN;
      load_bit_reg   <= 1'b0;
      freeze_bit_reg <= 1'b0;
      osc_stop_reg   <= 1'b0;
    end else begin
      if (!halted) begin                                                 // [RULE5] [RULE10] [RULE11]
        vis_sec_reg  <= cnt_sec_reg;
        vis_min_reg  <= cnt_min_reg;
        vis_hour_reg <= cnt_hour_reg;
        vis_day_reg  <= cnt_day_reg;
        vis_date_reg <= cnt_date_reg;
        vis_mon_reg  <= cnt_mon_reg;
        vis_year_reg <= cnt_year_reg;
        vis_cen_reg  <= cnt_cen_reg;
      end
      if (wr & clk_region) begin
        case (idx)
          `BW_ADDR_CTRL: begin
            load_bit_reg   <= DATA_LINE_IN[`BW_CTRL_LOAD];               // [RULE9]
            freeze_bit_reg <= DATA_LINE_IN[`BW_CTRL_FREEZE];             // [RULE10]
            if (load)
              vis_cen_reg <= DATA_LINE_IN[5:0];                          // [RULE12]
          end
          `BW_ADDR_SEC: begin
            vis_sec_reg  <= {1'b0, DATA_LINE_IN[6:0]};
            osc_stop_reg <= DATA_LINE_IN[`BW_SEC_OSC];
          end
          `BW_ADDR_MIN:  vis_min_reg  <= {1'b0, DATA_LINE_IN[6:0]};
          `BW_ADDR_HOUR: vis_hour_reg <= {2'b00, DATA_LINE_IN[5:0]};
          `BW_ADDR_DAY:  vis_day_reg  <= {5'h00, DATA_LINE_IN[2:0]};
          `BW_ADDR_DATE: vis_date_reg <= {2'b00, DATA_LINE_IN[5:0]};
          `BW_ADDR_MON:  vis_mon_reg  <= {3'b000, DATA_LINE_IN[4:0]};
          default:       vis_year_reg <= DATA_LINE_IN;
        endcase
      end
    end
  end

  always @* begin
    case (idx)
      `BW_ADDR_CTRL: clk_rd = {load_bit_reg, freeze_bit_reg, vis_cen_reg};
      `BW_ADDR_SEC:  clk_rd = {osc_stop_reg, vis_sec_reg[6:0]};
      `BW_ADDR_MIN:  clk_rd = {1'b0, vis_min_reg[6:0]};
      `BW_ADDR_HOUR: clk_rd = {2'b00, vis_hour_reg[5:0]};
      `BW_ADDR_DAY:  clk_rd = {batt_reg, 4'h0, vis_day_reg[2:0]};         // [RULE8]
      `BW_ADDR_DATE: clk_rd = {2'b00, vis_date_reg[5:0]};
      `BW_ADDR_MON:  clk_rd = {3'b000, vis_mon_reg[4:0]};
      default:       clk_rd = vis_year_reg;
    endcase
  end

  // byte array and the data lines
  always @(posedge CLOCK) begin
    if (wr & ~clk_region)
      mem[ADDRESS_LINE] <= DATA_LINE_IN;                                 // [RULE1]
  end

  always @(posedge CLOCK) begin
    if (!RSTN) begin
      DATA_LINE_OUT  <= 8'h00;
      DATA_LINE_OE_N <= 1'b1;
    end else begin
      DATA_LINE_OUT  <= clk_region ? clk_rd : mem[ADDRESS_LINE];         // [RULE1] [RULE2]
      DATA_LINE_OE_N <= ~rd;                                             // [RULE6] [RULE14]
    end
  end

  // interrupt events
  assign irq_ev[`BW_IRQ_TICK]  = step;
  assign irq_ev[`BW_IRQ_PFAIL] = POWER_BELOW_THRESHOLD & ~pf_reg;
  assign irq_ev[`BW_IRQ_READY] = ~pf_reg & (rec_reg == 13'h0001);
  assign irq_ev[`BW_IRQ_BATT]  = BATTERY_LOW & ~batt_reg;

  always @* begin
    irq_clr = 4'h0;
    if (ahb_wr_reg && ahb_addr_reg == `BW_AHB_IRQ_ST)
      irq_clr = HWDATA[3:0];
  end

  always @* begin
    ahb_rd = 32'h00000000;
    if (HADDR[31:4] == 28'h0000000) begin
      case (HADDR[3:0])
        `BW_AHB_IRQ_ST:  ahb_rd = {28'h0000000, irq_st_reg};
        `BW_AHB_IRQ_MSK: ahb_rd = {28'h0000000, irq_msk_reg};
        `BW_AHB_STATUS:  ahb_rd = {27'h0000000, freeze_bit_reg, load_bit_reg,
                                   batt_reg, blocked, pf_reg};
        default:         ahb_rd = 32'h00000000;
      endcase
    end
  end

  // AHB-Lite slave, zero wait states, always OKAY
  always @(posedge CLOCK) begin
    if (!RSTN) begin
      ahb_wr_reg   <= 1'b0;
      ahb_addr_reg <= 4'h0;
      HRDATA       <= 32'h00000000;
      HREADYOUT    <= 1'b1;
      HRESP        <= 1'b0;
      irq_st_reg   <= 4'h0;
      irq_msk_reg  <= 4'h0;
      IRQ          <= 1'b0;
    end else begin
      HREADYOUT  <= 1'b1;
      HRESP      <= 1'b0;
      ahb_wr_reg <= ahb_take & HWRITE & (HADDR[31:4] == 28'h0000000);
      if (ahb_take) begin
        ahb_addr_reg <= HADDR[3:0];
        HRDATA       <= ahb_rd;
      end
      if (ahb_wr_reg && ahb_addr_reg == `BW_AHB_IRQ_MSK)
        irq_msk_reg <= HWDATA[3:0];
      // a new event wins over a clear in the same cycle
      irq_st_reg <= (irq_st_reg & ~irq_clr) | irq_ev;
      IRQ        <= |(irq_st_reg & irq_msk_reg);
    end
  end

endmodule // bwrtc_top

`default_nettype wire

// >>> tb.sv
/*
  Self-checking bench of bwrtc_top: memory, calendar, freeze, supply blocking
  and the interrupt window. Short second and recovery counts are used.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        clock, rstn, cs_n, cs2, oe_n, we_n, pbt, batt, doe_n;
  logic        hsel, hwrite, hready, hresp, irq;
  logic [12:0] addr;
  logic [7:0]  din, dout;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata;
  int          err_total, check_count;
  bwrtc_top #(.SEC_CYCLES(25'd10), .REC_CYCLES(13'd8)) dut (.CLOCK(clock), .RSTN(rstn),
    .ADDRESS_LINE(addr), .DATA_LINE_IN(din), .DATA_LINE_OUT(dout), .DATA_LINE_OE_N(doe_n),
    .CHIP_SELECT_N(cs_n), .SECOND_CHIP_SELECT(cs2), .OUTPUT_ENABLE_N(oe_n),
    .WRITE_STROBE_N(we_n), .POWER_BELOW_THRESHOLD(pbt), .BATTERY_LOW(batt), .HSEL(hsel),
    .HADDR(haddr), .HWRITE(hwrite), .HTRANS(htrans), .HSIZE(hsize), .HWDATA(hwdata),
    .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .IRQ(irq));
  bwrtc_host host (.clock(clock), .addr_line(addr), .data_in(din), .cs_n(cs_n), .cs2(cs2),
    .oe_n(oe_n), .we_n(we_n), .data_out(dout), .data_oe_n(doe_n));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] rd);
    {hsel, hwrite, htrans, hsize} <= {1'b1, w, 5'b10010};
    haddr <= {24'h0, a};
    do @(posedge clock); while (hready !== 1'b1);
    {hsel, htrans} <= 3'b000;
    hwdata <= wd;
    do @(posedge clock); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic t_ram();
    logic [7:0] d;
    logic       ok;
    host.wr(13'h0000, 8'ha5);
    host.wr(13'h1ff7, 8'h5a);
    host.rd(13'h0000, 1'b1, d, ok);
    chk(32'({ok, d}), 32'h1a5, "ram low");
    host.rd(13'h1ff7, 1'b1, d, ok);
    chk(32'({ok, d}), 32'h15a, "ram top");
    host.rd(13'h1ff7, 1'b0, d, ok);
    chk(32'(ok), 32'h0, "second select low");
  endtask
  task automatic t_cal(input logic [7:0] yr, input logic [7:0] dd, input logic [7:0] mm);
    logic [63:0] exp, msk;
    logic [7:0]  d, s;
    logic        ok;
    int          i;
    exp = {yr, mm, dd, 32'h01000000, 8'h60};
    msk = 64'hffffff07fffff0ff;
    host.wr(13'h1ff8, 8'h80);
    host.wr(13'h1ff9, 8'h59);
    host.wr(13'h1ffa, 8'h59);
    host.wr(13'h1ffb, 8'h23);
    host.wr(13'h1ffc, 8'h07);
    host.wr(13'h1ffd, 8'h28);
    host.wr(13'h1ffe, 8'h02);
    host.wr(13'h1fff, yr);
    host.wr(13'h1ff8, 8'h20);
    repeat (15) @(posedge clock);
    host.wr(13'h1ff8, 8'h40);
    for (i = 0; i < 8; i++) begin
      host.rd(13'h1ff8 + 13'(i), 1'b1, d, ok);
      chk(32'({ok, d & msk[i*8 +: 8]}), 32'({1'b1, exp[i*8 +: 8]}), "clock byte");
    end
    host.rd(13'h1ff9, 1'b1, s, ok);
    repeat (40) @(posedge clock);
    host.rd(13'h1ff9, 1'b1, d, ok);
    chk(32'(d), 32'(s), "frozen seconds");
    host.thaw();
    host.rd(13'h1ffa, 1'b1, d, ok);
    chk(32'(d[7:1]), 32'h10, "minutes after freeze");
    host.rd(13'h1ff8, 1'b1, d, ok);
    chk(32'(d), 32'h20, "century kept");
  endtask
  task automatic t_power();
    logic [31:0] r;
    logic [7:0]  d;
    logic        ok;
    host.wr(13'h0100, 8'h3c);
    pbt <= 1'b1;
    repeat (3) @(posedge clock);
    host.wr(13'h0100, 8'hc3);
    host.rd(13'h0100, 1'b1, d, ok);
    chk(32'(ok), 32'h0, "read below threshold");
    ahb(8'h08, 1'b0, 32'h0, r);
    chk(r & 32'h3, 32'h3, "supply status");
    pbt <= 1'b0;
    @(posedge clock);
    host.rd(13'h0100, 1'b1, d, ok);
    chk(32'(ok), 32'h0, "read in recovery");
    repeat (12) @(posedge clock);
    host.rd(13'h0100, 1'b1, d, ok);
    chk(32'({ok, d}), 32'h13c, "ram after recovery");
  endtask
  task automatic t_irq();
    logic [31:0] r;
    logic [7:0]  d, s;
    logic        ok;
    ahb(8'h04, 1'b1, 32'h0, r);
    ahb(8'h00, 1'b1, 32'hf, r);
    batt <= 1'b1;
    repeat (3) @(posedge clock);
    chk(32'(irq), 32'h0, "masked irq");
    ahb(8'h08, 1'b0, 32'h0, r);
    chk(r & 32'h4, 32'h4, "battery status");
    host.rd(13'h1ffc, 1'b1, d, ok);
    chk(32'({ok, d[7]}), 32'h3, "battery flag");
    ahb(8'h04, 1'b1, 32'h8, r);
    repeat (2) @(posedge clock);
    chk(32'(irq), 32'h1, "irq raised");
    ahb(8'h00, 1'b1, 32'h8, r);
    repeat (2) @(posedge clock);
    chk(32'(irq), 32'h0, "irq cleared");
    ahb(8'h10, 1'b0, 32'h0, r);
    chk(r, 32'h0, "unmapped read");
    host.wr(13'h1ff9, 8'h80);
    host.rd(13'h1ff9, 1'b1, s, ok);
    repeat (40) @(posedge clock);
    host.rd(13'h1ff9, 1'b1, d, ok);
    chk(32'({s[7], d}), 32'({1'b1, s}), "stopped seconds");
    host.wr(13'h1ff9, 8'h00);
    batt <= 1'b0;
  endtask
  task automatic end_of_test();
    if (err_total == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    #2000000;
    err_total++;
    end_of_test();
  end
  initial begin
    {rstn, pbt, batt, hsel, hwrite, htrans, hsize} = 10'h0;
    {haddr, hwdata} = 64'h0;
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    t_ram();
    t_cal(8'h24, 8'h29, 8'h02);
    t_cal(8'h23, 8'h01, 8'h03);
    t_power();
    t_irq();
    end_of_test();
  end
endmodule // tb
`default_nettype wire
